// >>> logic/fpad_pkg.sv
// Behaviour
// R1: writing one to soft reset clears control and system registers; bit self-clears. The code keeps endian_sel over soft reset.
// R2: soft reset clears latched transmit and receive error flags.
// R3: host requests soft reset only once the phy is operational.
// R4: host writes are ignored until at least one read after reset or wake.
// R5: transmit size is total transmit space in kilobytes; status queue fixed 512 bytes.
// R6: transmit data queue is total transmit space minus the status queue.
// R7: total receive space is 16384 bytes minus total transmit space.
// R8: receive status queue is one sixteenth of receive space; data queue the rest.
// R9: software programs transmit size only from 2 through 14.
// R10: receive data queue reads full four doublewords before its length.
// R11: fixed staging buffers of 2k bytes transmit and 128 bytes receive.
// R12: transmit staging buffer refills from the data queue as space frees.
// R13: receive data goes staging buffer then data queue; waits in staging when full.
// R14: on receive staging overrun drop later frames and count each lost frame.
// R15: staging levels are hidden; reported queue levels exclude staging contents.
// R16: writing bit 31 of receive datapath control skips to next frame; reads high meanwhile.
// R17: host must not read the receive data queue while the skip bit is high.
// R18: soft reset with phy down does not complete; timeout flag is set.
// R19: transmit size is bits 19:16 of hardware configuration, reset value 5.
// R20: change transmit size only while all queues are empty.
package fpad_pkg;
   localparam logic [7:0] fpad_addr_hardware_configuration = 8'h74;
   localparam logic [7:0] fpad_addr_receive_datapath_control = 8'h78;
   localparam logic [7:0] fpad_addr_rx_info = 8'h7c;
   localparam logic [7:0] fpad_addr_tx_info = 8'h80;
   localparam logic [7:0] fpad_addr_drop_cnt = 8'ha0;
   localparam logic [7:0] fpad_addr_err = 8'ha4;
   localparam int fpad_soft_reset_request_bit = 0;
   localparam int fpad_soft_reset_timeout_flag_bit = 1;
   localparam int fpad_txsz_lsb = 16;
   localparam int fpad_mbo_bit = 20;
   localparam int fpad_endian_lsb = 28;
   localparam int fpad_ffwd_bit = 31;
   localparam logic [3:0] fpad_txsz_reset = 4'h5;
   localparam logic [3:0] fpad_txsz_min = 4'h2;
   localparam logic [3:0] fpad_txsz_max = 4'he;
   localparam logic [15:0] fpad_total_bytes = 16'h4000;
   localparam logic [15:0] fpad_tx_stat_bytes = 16'h0200;
   localparam logic [15:0] fpad_rx_full_margin = 16'h0010;
   localparam int fpad_tx_stage_bytes = 2048;
   localparam int fpad_rx_stage_bytes = 128;
   localparam real fpad_clk_mhz = 20.0;
   localparam real fpad_soft_reset_timeout_flag_us = 100.0;
   localparam int fpad_soft_reset_timeout_flag_cycles = $rtoi(fpad_soft_reset_timeout_flag_us * fpad_clk_mhz);
endpackage

// >>> logic/fpad_stage.sv
`timescale 1ns/1ps
// fixed staging byte counter between a source and a sink
module fpad_stage #(
   parameter int depth = 128
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic clear,
   input wire logic put,
   input wire logic take,
   output logic [15:0] level,
   output logic room,
   output logic avail
);
   always_comb
   begin
      room = (level < 16'(depth));
      avail = (level != 16'h0000);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn || (ce && clear))
         level <= 16'h0000;
      else if (ce)
         level <= level + 16'(put && room) - 16'(take && avail);
   end
endmodule

// >>> logic/fpad_top.sv
`timescale 1ns/1ps
module fpad_top #(
   parameter int soft_reset_timeout_flag_cycles = fpad_pkg::fpad_soft_reset_timeout_flag_cycles,
   parameter int tx_stage_depth = fpad_pkg::fpad_tx_stage_bytes,
   parameter int rx_stage_depth = fpad_pkg::fpad_rx_stage_bytes
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic phy_ready,
   input wire logic wake_event,
   input wire logic tx_q_wr,
   input wire logic tx_stat_wr,
   input wire logic tx_stat_rd,
   input wire logic mac_tx_take,
   input wire logic mac_rx_put,
   input wire logic mac_rx_sof,
   input wire logic rx_q_rd,
   input wire logic rx_stat_wr,
   input wire logic rx_stat_rd,
   input wire logic rx_frame_end,
   input wire logic tx_err_in,
   input wire logic rx_err_in,
   output logic [15:0] tx_data_bytes,
   output logic [15:0] tx_stat_bytes,
   output logic [15:0] rx_data_bytes,
   output logic [15:0] rx_stat_bytes,
   output logic rx_q_full,
   output logic tx_q_full,
   output logic mac_tx_avail,
   output logic mac_rx_room,
   output logic soft_reset_pulse,
   output logic [1:0] endian_sel
);
   typedef enum logic [1:0] {fpad_idle, fpad_wait_phy, fpad_done} fpad_soft_reset_request_t;

   fpad_soft_reset_request_t soft_reset_request_state;
   logic armed;
   logic [3:0] transmit_allocation_size;
   logic mbo;
   logic soft_reset_timeout_flag;
   logic receive_frame_skip;
   logic transmit_error_flag;
   logic receive_error_flag;
   logic [31:0] drop_count;
   logic [15:0] tx_q_level;
   logic [15:0] rx_q_level;
   logic [7:0] tx_stat_level;
   logic [7:0] rx_stat_level;
   logic [31:0] soft_reset_request_cnt;
   logic dropping;
   logic soft_clear;
   logic wr_ok;
   logic [15:0] tx_stage_level;
   logic [15:0] rx_stage_level;
   logic tx_stage_room;
   logic rx_stage_avail;
   logic tx_move;
   logic rx_move;

   function automatic logic [15:0] fpad_kbytes(input logic [3:0] sz);
      fpad_kbytes = {2'b00, sz, 10'h000};
   endfunction

   // [R5] [R6] [R7] [R8]
   always_comb
   begin
      tx_stat_bytes = fpad_pkg::fpad_tx_stat_bytes;
      tx_data_bytes = fpad_kbytes(transmit_allocation_size) - fpad_pkg::fpad_tx_stat_bytes;
      rx_stat_bytes = (fpad_pkg::fpad_total_bytes - fpad_kbytes(transmit_allocation_size)) >> 4;
      rx_data_bytes = fpad_pkg::fpad_total_bytes - fpad_kbytes(transmit_allocation_size)
         - rx_stat_bytes;
   end

   // [R10]
   assign rx_q_full = (rx_q_level + fpad_pkg::fpad_rx_full_margin >= rx_data_bytes);
   assign tx_q_full = (tx_q_level >= tx_data_bytes);
   assign soft_clear = ce && wr && wr_ok && addr == fpad_pkg::fpad_addr_hardware_configuration
      && wdata[fpad_pkg::fpad_soft_reset_request_bit] && soft_reset_request_state == fpad_idle;
   assign soft_reset_pulse = (soft_reset_request_state == fpad_done);
   // [R4]
   assign wr_ok = armed;

   // write gate: armed after a read, dropped again by reset or wake
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         armed <= 1'b0;
      else if (ce)
      begin
         if (wake_event || soft_reset_pulse)
            armed <= 1'b0; // [R4]
         else if (rd)
            armed <= 1'b1; // [R4]
      end
   end

   // soft reset sequencer waits for the phy, else times out
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         soft_reset_request_state <= fpad_idle;
         soft_reset_request_cnt <= 32'h0;
         soft_reset_timeout_flag <= 1'b0;
      end
      else if (ce)
      begin
         unique case (soft_reset_request_state)
            fpad_idle:
            begin
               soft_reset_request_cnt <= 32'h0;
               if (soft_clear)
               begin
                  soft_reset_request_state <= fpad_wait_phy;
                  soft_reset_timeout_flag <= 1'b0;
               end
            end
            fpad_wait_phy:
            begin
               soft_reset_request_cnt <= soft_reset_request_cnt + 32'h1;
               if (phy_ready)
                  soft_reset_request_state <= fpad_done; // [R1]
               else if (soft_reset_request_cnt >= 32'(soft_reset_timeout_flag_cycles - 1))
               begin
                  soft_reset_request_state <= fpad_idle;
                  soft_reset_timeout_flag <= 1'b1; // [R18]
               end
            end
            fpad_done:
               soft_reset_request_state <= fpad_idle; // [R1]
         endcase
      end
   end

   // configuration, with kept bits surviving soft reset
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         transmit_allocation_size <= fpad_pkg::fpad_txsz_reset;
         mbo <= 1'b0;
         endian_sel <= 2'b00;
      end
      else if (ce)
      begin
         if (soft_reset_pulse)
         begin
            transmit_allocation_size <= fpad_pkg::fpad_txsz_reset; // [R1]
            mbo <= 1'b0;
         end
         else if (wr && wr_ok && addr == fpad_pkg::fpad_addr_hardware_configuration)
         begin
            // [R19] [R9]
            if (wdata[fpad_pkg::fpad_txsz_lsb +: 4] >= fpad_pkg::fpad_txsz_min
               && wdata[fpad_pkg::fpad_txsz_lsb +: 4] <= fpad_pkg::fpad_txsz_max)
               transmit_allocation_size <= wdata[fpad_pkg::fpad_txsz_lsb +: 4];
            mbo <= wdata[fpad_pkg::fpad_mbo_bit];
            endian_sel <= wdata[fpad_pkg::fpad_endian_lsb +: 2];
         end
      end
   end

   // latched errors, set wins over soft clear
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         transmit_error_flag <= 1'b0;
         receive_error_flag <= 1'b0;
      end
      else if (ce)
      begin
         transmit_error_flag <= tx_err_in || (transmit_error_flag && !soft_reset_pulse); // [R2]
         receive_error_flag <= rx_err_in || (receive_error_flag && !soft_reset_pulse); // [R2]
      end
   end

   // staging buffers
   fpad_stage #(.depth(tx_stage_depth)) u_tx_stage ( // [R11]
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .clear(soft_reset_pulse),
      .put(tx_move),
      .take(mac_tx_take),
      .level(tx_stage_level),
      .room(tx_stage_room),
      .avail(mac_tx_avail)
   );

   fpad_stage #(.depth(rx_stage_depth)) u_rx_stage ( // [R11]
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .clear(soft_reset_pulse),
      .put(mac_rx_put && !dropping),
      .take(rx_move),
      .level(rx_stage_level),
      .room(mac_rx_room),
      .avail(rx_stage_avail)
   );

   assign tx_move = tx_stage_room && (tx_q_level != 16'h0); // [R12]
   assign rx_move = rx_stage_avail && !rx_q_full; // [R13]

   // host queue levels exclude staging contents
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         tx_q_level <= 16'h0;
         rx_q_level <= 16'h0;
         tx_stat_level <= 8'h0;
         rx_stat_level <= 8'h0;
      end
      else if (ce)
      begin
         if (soft_reset_pulse)
         begin
            tx_q_level <= 16'h0;
            rx_q_level <= 16'h0;
            tx_stat_level <= 8'h0;
            rx_stat_level <= 8'h0;
         end
         else
         begin
            tx_q_level <= tx_q_level + 16'(tx_q_wr && !tx_q_full) - 16'(tx_move); // [R15]
            if (receive_frame_skip && rx_frame_end)
               rx_q_level <= 16'h0; // [R16]
            else
               rx_q_level <= rx_q_level + 16'(rx_move)
                  - 16'(rx_q_rd && rx_q_level != 16'h0 && !receive_frame_skip); // [R15] [R17]
            tx_stat_level <= tx_stat_level + 8'(tx_stat_wr) - 8'(tx_stat_rd && tx_stat_level != 8'h0);
            rx_stat_level <= rx_stat_level + 8'(rx_stat_wr) - 8'(rx_stat_rd && rx_stat_level != 8'h0);
         end
      end
   end

   // frame skip bit holds high until the frame end is reached
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         receive_frame_skip <= 1'b0;
      else if (ce)
      begin
         if (soft_reset_pulse || (receive_frame_skip && rx_frame_end))
            receive_frame_skip <= 1'b0; // [R16]
         else if (wr && wr_ok && addr == fpad_pkg::fpad_addr_receive_datapath_control
            && wdata[fpad_pkg::fpad_ffwd_bit])
            receive_frame_skip <= 1'b1; // [R16]
      end
   end

   // overrun drop: lose the rest of the overrun frame and whole later frames, count each one
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         dropping <= 1'b0;
         drop_count <= 32'h0;
      end
      else if (ce)
      begin
         if (soft_reset_pulse)
         begin
            dropping <= 1'b0;
            drop_count <= 32'h0;
         end
         else if (mac_rx_sof)
         begin
            dropping <= !mac_rx_room; // [R13] [R14]
            if (!mac_rx_room)
               drop_count <= drop_count + 32'h1; // [R14]
         end
         else if (mac_rx_put && !mac_rx_room && !dropping)
         begin
            dropping <= 1'b1; // [R14]
            drop_count <= drop_count + 32'h1;
         end
      end
   end

   // read data
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         rdata <= 32'h0;
      else if (ce)
      begin
         rdata <= 32'h0;
         if (rd)
         begin
            unique case (addr)
               fpad_pkg::fpad_addr_hardware_configuration:
                  rdata <= {1'b0, 1'b0, endian_sel, 7'h0, mbo, transmit_allocation_size,
                     14'h0, soft_reset_timeout_flag, 1'b0}; // [R18] [R19]
               fpad_pkg::fpad_addr_receive_datapath_control:
                  rdata <= {receive_frame_skip, 31'h0}; // [R16]
               fpad_pkg::fpad_addr_rx_info:
                  rdata <= {8'h0, rx_stat_level, rx_q_level}; // [R15]
               fpad_pkg::fpad_addr_tx_info:
                  rdata <= {8'h0, tx_stat_level, tx_data_bytes - tx_q_level}; // [R15]
               fpad_pkg::fpad_addr_drop_cnt:
                  rdata <= drop_count;
               fpad_pkg::fpad_addr_err:
                  rdata <= {30'h0, receive_error_flag, transmit_error_flag};
               default:
                  rdata <= 32'h0;
            endcase
         end
      end
   end

   sequence skip_req_s;
      ce && wr && wr_ok && addr == fpad_pkg::fpad_addr_receive_datapath_control && wdata[31] && !soft_reset_pulse;
   endsequence

   skip_sets_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
      skip_req_s |=> receive_frame_skip)
      else $error("skip bit not set");
   write_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
      (!armed && ce && wr && addr == fpad_pkg::fpad_addr_hardware_configuration && !soft_reset_pulse)
      |=> $stable(transmit_allocation_size))
      else $error("write taken before read");
   rx_full_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
      rx_q_full == (rx_q_level >= rx_data_bytes - 16'h10))
      else $error("rx full margin wrong");
   rx_split_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
      (rx_stat_bytes << 4) == rx_stat_bytes + rx_data_bytes
      && rx_stat_bytes + rx_data_bytes + tx_data_bytes + tx_stat_bytes == 16'h4000)
      else $error("partition mismatch");
   txsz_range_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
      transmit_allocation_size >= 4'h2 && transmit_allocation_size <= 4'he)
      else $error("tx size out of range");
   soft_reset_request_self_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
      soft_reset_pulse && ce |=> !soft_reset_pulse)
      else $error("soft reset not self clearing");
   err_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
      soft_reset_pulse && ce && !tx_err_in |=> !transmit_error_flag)
      else $error("tx error not cleared");
   drop_count_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
      ce && mac_rx_sof && !soft_reset_pulse && !mac_rx_room
      |=> drop_count == $past(drop_count) + 32'h1)
      else $error("drop not counted");
endmodule

// >>> test/fpad_mac_model.sv
`timescale 1ns/1ps
// mac side: sends receive frames byte by byte, pulls transmit bytes
module fpad_mac_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic send,
   input wire logic slow,
   input wire logic [15:0] frame_len,
   input wire logic tx_pull,
   input wire logic mac_tx_avail,
   output logic mac_rx_put,
   output logic mac_rx_sof,
   output logic mac_tx_take,
   output logic busy
);
   logic [15:0] left;
   logic ph;
   assign busy = left != 16'h0000;
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         left <= 16'h0000;
         ph <= 1'b0;
         mac_rx_put <= 1'b0;
         mac_rx_sof <= 1'b0;
         mac_tx_take <= 1'b0;
      end
      else
      begin
         ph <= ~ph;
         mac_rx_sof <= send && !busy;
         mac_rx_put <= busy && (!slow || ph);
         // every other cycle, so a lagging avail never overdraws
         mac_tx_take <= tx_pull && mac_tx_avail && !mac_tx_take;
         if (send && !busy)
            left <= frame_len;
         else if (busy && (!slow || ph))
            left <= left - 16'h0001;
      end
   end
endmodule

// >>> test/fifo_partition_and_rx_discard_tb.sv
`timescale 1ns/1ps
module fifo_partition_and_rx_discard_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, phy_ready = 1'b1, wake_event = 1'b0, tx_q_wr = 1'b0;
   logic rx_stat_wr = 1'b0, tx_err_in = 1'b0, rx_err_in = 1'b0, rx_frame_end = 1'b0;
   logic send = 1'b0, slow = 1'b0, tx_pull = 1'b0;
   logic ce = 1'b1, rx_q_rd = 1'b0;
   logic [15:0] frame_len = 16'h0000;
   logic [31:0] rdata, d;
   logic [15:0] txd, txs, rxd, rxs;
   logic rx_full, tx_full, tx_avail, rx_room, soft_reset_request_pulse, put, sof, take, busy, seen;
   logic [1:0] endian;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;
   fpad_top #(.soft_reset_timeout_flag_cycles(8)) dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phy_ready(phy_ready),
      .wake_event(wake_event), .tx_q_wr(tx_q_wr), .tx_stat_wr(1'b0), .tx_stat_rd(1'b0),
      .mac_tx_take(take), .mac_rx_put(put), .mac_rx_sof(sof), .rx_q_rd(rx_q_rd),
      .rx_stat_wr(rx_stat_wr), .rx_stat_rd(1'b0), .rx_frame_end(rx_frame_end),
      .tx_err_in(tx_err_in), .rx_err_in(rx_err_in), .tx_data_bytes(txd), .tx_stat_bytes(txs),
      .rx_data_bytes(rxd), .rx_stat_bytes(rxs), .rx_q_full(rx_full), .tx_q_full(tx_full),
      .mac_tx_avail(tx_avail), .mac_rx_room(rx_room), .soft_reset_pulse(soft_reset_request_pulse),
      .endian_sel(endian));
   fpad_mac_model mac (.clk_sys(clk_sys), .resetn(resetn), .send(send), .slow(slow),
      .frame_len(frame_len), .tx_pull(tx_pull), .mac_tx_avail(tx_avail), .mac_rx_put(put),
      .mac_rx_sof(sof), .mac_tx_take(take), .busy(busy));
   initial
   begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   function automatic logic [31:0] hwv(input logic [3:0] k);
      return {2'b00, 2'b10, 7'h00, 1'b1, k, 16'h0000};
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_pulse(input int n, output logic s);
      s = 1'b0;
      repeat (n)
      begin
         @(posedge clk_sys);
         #1 if (soft_reset_request_pulse === 1'b1) s = 1'b1;
      end
   endtask
   task automatic frame(input logic [15:0] n);
      @(posedge clk_sys);
      frame_len <= n;
      send <= 1'b1;
      @(posedge clk_sys);
      send <= 1'b0;
      repeat (2 * n + 300) @(posedge clk_sys);
   endtask
   task automatic check_sizes(input int k);
      chk("tx data size", k * 1024 - 512, {16'h0, txd});
      chk("tx stat size", 512, {16'h0, txs});
      chk("rx stat size", (16384 - k * 1024) / 16, {16'h0, rxs});
      chk("rx data size", (16384 - k * 1024) * 15 / 16, {16'h0, rxd});
   endtask
   task automatic t_first_read;
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'h6));
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("size field", 32'h5, {28'h0, d[19:16]});
      check_sizes(5);
   endtask
   task automatic t_partition;
      for (int k = 2; k <= 15; k++)
      begin
         wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'(k)));
         rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
         chk("size field", (k == 15) ? 14 : k, {28'h0, d[19:16]});
         check_sizes((k == 15) ? 14 : k);
      end
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'h1));
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("size field", 32'he, {28'h0, d[19:16]});
   endtask
   task automatic t_rx_full_drop;
      frame(16'd1900);
      chk_bit("rx full", 1'b0, rx_full);
      frame(16'd4);
      chk_bit("rx full", 1'b1, rx_full);
      @(posedge clk_sys);
      rx_stat_wr <= 1'b1;
      @(posedge clk_sys);
      rx_stat_wr <= 1'b0;
      rd_reg(fpad_pkg::fpad_addr_rx_info, d);
      chk("rx info", 32'h0001_0770, d);
      slow <= 1'b1;
      frame(16'd200);
      frame(16'd8);
      slow <= 1'b0;
      rd_reg(fpad_pkg::fpad_addr_drop_cnt, d);
      chk("drop count", 32'h2, d);
      chk_bit("rx room", 1'b0, rx_room);
   endtask
   task automatic t_skip;
      // no data queue read while skipping
      wr_reg(fpad_pkg::fpad_addr_receive_datapath_control, 32'h8000_0000);
      rd_reg(fpad_pkg::fpad_addr_receive_datapath_control, d);
      chk_bit("skip bit", 1'b1, d[31]);
      @(posedge clk_sys);
      rx_frame_end <= 1'b1;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
      rd_reg(fpad_pkg::fpad_addr_receive_datapath_control, d);
      chk_bit("skip bit", 1'b0, d[31]);
      repeat (140) @(posedge clk_sys);
      chk_bit("rx room", 1'b1, rx_room);
      rx_q_rd <= 1'b1;
      @(posedge clk_sys);
      rx_q_rd <= 1'b0;
      rd_reg(fpad_pkg::fpad_addr_rx_info, d);
      chk("rx info", 32'h0001_007f, d);
   endtask
   task automatic t_tx_move;
      @(posedge clk_sys);
      tx_q_wr <= 1'b1;
      repeat (4) @(posedge clk_sys);
      tx_q_wr <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1 chk_bit("tx avail", 1'b1, tx_avail);
      chk_bit("tx full", 1'b0, tx_full);
      rd_reg(fpad_pkg::fpad_addr_tx_info, d);
      chk("tx info", 32'h0000_3600, d);
      @(posedge clk_sys);
      tx_pull <= 1'b1;
      repeat (40) @(posedge clk_sys);
      tx_pull <= 1'b0;
      #1 chk_bit("tx avail", 1'b0, tx_avail);
   endtask
   task automatic t_soft_reset;
      @(posedge clk_sys);
      tx_err_in <= 1'b1;
      rx_err_in <= 1'b1;
      @(posedge clk_sys);
      tx_err_in <= 1'b0;
      rx_err_in <= 1'b0;
      rd_reg(fpad_pkg::fpad_addr_err, d);
      chk("errors", 32'h3, d);
      phy_ready <= 1'b0;
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'he) | 32'h1);
      wait_pulse(20, seen);
      chk_bit("reset pulse", 1'b0, seen);
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk_bit("timeout flag", 1'b1, d[1]);
      phy_ready <= 1'b1; // phy up before request
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'he) | 32'h1);
      wait_pulse(20, seen);
      chk_bit("reset pulse", 1'b1, seen);
      rd_reg(fpad_pkg::fpad_addr_err, d);
      chk("errors", 32'h0, d);
      rd_reg(fpad_pkg::fpad_addr_drop_cnt, d);
      chk("drop count", 32'h0, d);
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("hardware_configuration", 32'h0005_0000, d & 32'h000f_0003);
      chk("endian", 32'h2, {30'h0, endian});
      check_sizes(5);
   endtask
   task automatic t_wake;
      @(posedge clk_sys);
      wake_event <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'h7));
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("size field", 32'h5, {28'h0, d[19:16]});
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'h7)); // queues empty
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("size field", 32'h7, {28'h0, d[19:16]});
      @(posedge clk_sys);
      ce <= 1'b0;
      wr_reg(fpad_pkg::fpad_addr_hardware_configuration, hwv(4'h9));
      ce <= 1'b1;
      rd_reg(fpad_pkg::fpad_addr_hardware_configuration, d);
      chk("size field", 32'h7, {28'h0, d[19:16]});
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_first_read;
      t_partition;
      t_rx_full_drop;
      t_skip;
      t_tx_move;
      t_soft_reset;
      t_wake;
      print_verdict;
   end
endmodule
